// ==== hw/waveform_offset_audio_ctrl_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module waveform_offset_audio_ctrl_regs
	import wave_adj_pkg::*;
#(
	parameter int DUR_W = 16
)
(
	input  wire logic             i_clk,
	input  wire logic             i_srst,
	input  wire logic [7:0]       i_reg_addr,
	input  wire logic             i_reg_wr,
	input  wire logic             i_reg_rd,
	input  wire logic [7:0]       i_reg_wdata,
	output logic      [7:0]       o_reg_rdata,
	input  wire logic             i_closed_loop,
	input  wire logic [3:0]       i_playback_step_time,
	input  wire logic             i_wave_start,
	input  wire logic             i_scan_valid,
	input  wire logic [7:0]       i_scan_level,
	input  wire logic             i_scan_done,
	input  wire logic             i_seg_valid,
	input  wire logic [7:0]       i_seg_level,
	input  wire logic [DUR_W-1:0] i_seg_dur,
	output logic                  o_seg_ready,
	output logic                  o_adj_valid,
	output seg_class_type         o_adj_class,
	output logic      [DUR_W-1:0] o_adj_dur,
	output logic      [5:0]       o_audio_peak_window_ms,
	output logic      [7:0]       o_audio_lowpass_hz
);

	typedef struct packed {
		fsm_type          st;
		logic [7:0]       sustain_pos_offset;
		logic [7:0]       sustain_neg_offset;
		logic [7:0]       brake_offset;
		logic [1:0]       audio_peak_window;
		logic [1:0]       audio_lowpass_corner;
		logic [7:0]       max_lvl;
		logic [7:0]       min_lvl;
		logic [7:0]       rdata;
		logic             adj_valid;
		seg_class_type    adj_class;
		logic [DUR_W-1:0] adj_dur;
	} regs_type;

	regs_type      r;
	regs_type      next_r;
	seg_class_type seg_cls;
	logic          seg_fire;

	wave_adj_if #(.DUR_W(DUR_W)) adj ();

	wave_segment_adjust u_adjust (
		.adj (adj.calc)
	);

	// classify the incoming segment against the scanned extrema
	assign seg_fire = (r.st == ST_PLAY) && i_seg_valid;
	assign seg_cls  = classify(i_seg_level, r.max_lvl, r.min_lvl);

	// pick the offset for the segment kind; overdrive passes unchanged here
	always_comb
	begin
		adj.dur    = i_seg_dur;
		adj.step   = i_playback_step_time;
		adj.offset = 8'h00;
		unique case (seg_cls)
			SEG_SUS_POS: adj.offset = r.sustain_pos_offset;
			SEG_SUS_NEG: adj.offset = r.sustain_neg_offset;
			SEG_BRAKE:   adj.offset = i_closed_loop ? 8'h00 : r.brake_offset;
			SEG_OVERDRIVE, SEG_ZERO: adj.offset = 8'h00;
			default:     adj.offset = 8'h00;
		endcase
	end

	// next state: registers, scan, and the adjusted segment
	always_comb
	begin
		next_r           = r;
		next_r.adj_valid = 1'b0;
		if (i_reg_wr)
		begin
			unique case (i_reg_addr)
				ADDR_SUS_POS: next_r.sustain_pos_offset = i_reg_wdata;
				ADDR_SUS_NEG: next_r.sustain_neg_offset = i_reg_wdata;
				ADDR_BRAKE:   next_r.brake_offset       = i_reg_wdata;
				ADDR_AUDIO:
				begin
					next_r.audio_peak_window    = i_reg_wdata[PEAK_LSB +: 2];
					next_r.audio_lowpass_corner = i_reg_wdata[LPF_LSB +: 2];
				end
				default: ;
			endcase
		end
		if (i_reg_rd)
		begin
			unique case (i_reg_addr)
				ADDR_SUS_POS: next_r.rdata = r.sustain_pos_offset;
				ADDR_SUS_NEG: next_r.rdata = r.sustain_neg_offset;
				ADDR_BRAKE:   next_r.rdata = r.brake_offset;
				ADDR_AUDIO:   next_r.rdata = {4'h0, r.audio_peak_window,
					r.audio_lowpass_corner};
				default:      next_r.rdata = 8'h00;
			endcase
		end
		// a restart wins over any scan or play step in flight; register writes and reads still land
		if (i_wave_start)
		begin
			next_r.st      = ST_SCAN;
			next_r.max_lvl = SCAN_MAX_SEED;
			next_r.min_lvl = SCAN_MIN_SEED;
		end
		else
		begin
			unique case (r.st)
				ST_IDLE: ;
				ST_SCAN:
				begin
					if (i_scan_valid && $signed(i_scan_level) > $signed(r.max_lvl))
						next_r.max_lvl = i_scan_level;
					if (i_scan_valid && $signed(i_scan_level) < $signed(r.min_lvl))
						next_r.min_lvl = i_scan_level;
					if (i_scan_done)
						next_r.st = ST_PLAY;
				end
				ST_PLAY:
				begin
					if (seg_fire)
					begin
						next_r.adj_valid = 1'b1;
						next_r.adj_class = seg_cls;
						next_r.adj_dur   = adj.result;
					end
				end
				default: next_r.st = ST_IDLE;
			endcase
		end
	end

	// single register stage for all state
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			r.st                   <= ST_IDLE;
			r.sustain_pos_offset   <= RST_OFFSET;
			r.sustain_neg_offset   <= RST_OFFSET;
			r.brake_offset         <= RST_OFFSET;
			r.audio_peak_window    <= RST_PEAK_CODE;
			r.audio_lowpass_corner <= RST_LPF_CODE;
			r.max_lvl              <= SCAN_MAX_SEED;
			r.min_lvl              <= SCAN_MIN_SEED;
			r.rdata                <= 8'h00;
			r.adj_valid            <= 1'b0;
			r.adj_class            <= SEG_ZERO;
			r.adj_dur              <= '0;
		end
		else
			r <= next_r;
	end

	// outputs; audio settings decode straight from stored codes
	assign o_reg_rdata            = r.rdata;
	assign o_seg_ready            = (r.st == ST_PLAY);
	assign o_adj_valid            = r.adj_valid;
	assign o_adj_class            = r.adj_class;
	assign o_adj_dur              = r.adj_dur;
	assign o_audio_peak_window_ms = peak_window_ms(r.audio_peak_window);
	assign o_audio_lowpass_hz     = lowpass_hz(r.audio_lowpass_corner);

	// checks on the adjusted segment path
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);

	logic small_dur;
	assign small_dur = (i_seg_dur < DUR_W'(16'h4000));

	a_pos_stretch: assert property (
		seg_fire && seg_cls == SEG_SUS_POS && r.sustain_pos_offset == 8'h01 && small_dur
		|=> o_adj_valid && o_adj_dur == DUR_W'($past(i_seg_dur)
			+ DUR_W'($past(i_playback_step_time))))
		else $error("positive sustain not lengthened by one step");

	a_pos_signed: assert property (
		seg_fire && seg_cls == SEG_SUS_POS && r.sustain_pos_offset[7]
		|=> o_adj_dur <= $past(i_seg_dur))
		else $error("negative positive-sustain offset lengthened segment");

	a_pos_class: assert property (
		seg_fire && $signed(i_seg_level) > 0 && i_seg_level != r.max_lvl
		|=> o_adj_class == SEG_SUS_POS)
		else $error("positive level not taken as positive sustain");

	a_neg_stretch: assert property (
		seg_fire && seg_cls == SEG_SUS_NEG && r.sustain_neg_offset == 8'h02 && small_dur
		|=> o_adj_dur == DUR_W'($past(i_seg_dur)
			+ DUR_W'({$past(i_playback_step_time), 1'b0})))
		else $error("negative sustain not lengthened by two steps");

	a_neg_signed: assert property (
		seg_fire && seg_cls == SEG_SUS_NEG && r.sustain_neg_offset == 8'hFF
		&& i_seg_dur >= DUR_W'(i_playback_step_time)
		|=> o_adj_dur == DUR_W'($past(i_seg_dur)
			- DUR_W'($past(i_playback_step_time))))
		else $error("negative sustain minus one step wrong");

	a_neg_class: assert property (
		seg_fire && $signed(i_seg_level) < 0 && i_seg_level != r.min_lvl
		|=> o_adj_class == SEG_SUS_NEG)
		else $error("negative level not taken as negative sustain");

	a_brake_open: assert property (
		seg_fire && seg_cls == SEG_BRAKE && !i_closed_loop
		&& r.brake_offset == 8'h01 && small_dur
		|=> o_adj_class == SEG_BRAKE && o_adj_dur == DUR_W'($past(i_seg_dur)
			+ DUR_W'($past(i_playback_step_time))))
		else $error("open loop brake not lengthened");

	a_brake_min: assert property (
		seg_fire && $signed(i_seg_level) < 0 && i_seg_level == r.min_lvl
		|=> o_adj_valid && o_adj_class == SEG_BRAKE)
		else $error("most negative level not taken as brake");

	// the scan must track the true extrema, or classification is meaningless
	a_min_track: assert property (
		r.st == ST_SCAN && !i_wave_start && i_scan_valid
		&& $signed(i_scan_level) < $signed(r.min_lvl)
		|=> r.min_lvl == $past(i_scan_level))
		else $error("lower scanned level not kept as minimum");

	a_min_hold: assert property (
		r.st == ST_SCAN && !i_wave_start
		&& !(i_scan_valid && $signed(i_scan_level) < $signed(r.min_lvl))
		|=> $stable(r.min_lvl))
		else $error("scan minimum moved without a lower level");

	a_max_track: assert property (
		r.st == ST_SCAN && !i_wave_start && i_scan_valid
		&& $signed(i_scan_level) > $signed(r.max_lvl)
		|=> r.max_lvl == $past(i_scan_level))
		else $error("higher scanned level not kept as maximum");

	// sign guards: brake only below zero, overdrive only above
	a_brake_neg: assert property (
		seg_fire && $signed(i_seg_level) >= 0
		|=> o_adj_class != SEG_BRAKE)
		else $error("non-negative level taken as brake");

	a_od_pos: assert property (
		seg_fire && $signed(i_seg_level) <= 0
		|=> o_adj_class != SEG_OVERDRIVE)
		else $error("non-positive level taken as overdrive");

	a_zero_level: assert property (
		seg_fire && i_seg_level == 8'h00
		|=> o_adj_class == SEG_ZERO && o_adj_dur == $past(i_seg_dur))
		else $error("zero level not passed unchanged");

	// offset writes land in the register that the adjuster reads
	a_pos_write: assert property (
		i_reg_wr && i_reg_addr == ADDR_SUS_POS
		|=> r.sustain_pos_offset == $past(i_reg_wdata))
		else $error("positive sustain offset not stored");

	a_neg_write: assert property (
		i_reg_wr && i_reg_addr == ADDR_SUS_NEG
		|=> r.sustain_neg_offset == $past(i_reg_wdata))
		else $error("negative sustain offset not stored");

	a_brake_write: assert property (
		i_reg_wr && i_reg_addr == ADDR_BRAKE
		|=> r.brake_offset == $past(i_reg_wdata))
		else $error("brake offset not stored");

	a_brake_closed: assert property (
		seg_fire && seg_cls == SEG_BRAKE && i_closed_loop
		|=> o_adj_dur == $past(i_seg_dur))
		else $error("brake offset applied in closed loop");

	a_peak_window: assert property (
		i_reg_wr && i_reg_addr == ADDR_AUDIO && i_reg_wdata[3:2] == 2'h3
		|=> o_audio_peak_window_ms == 6'h28)
		else $error("peak window code 3 is not 40 ms");

	a_lowpass: assert property (
		i_reg_wr && i_reg_addr == ADDR_AUDIO && i_reg_wdata[1:0] == 2'h0
		|=> o_audio_lowpass_hz == 8'h64)
		else $error("lowpass code 0 is not 100 Hz");

	a_overdrive: assert property (
		seg_fire && $signed(i_seg_level) > 0 && i_seg_level == r.max_lvl
		|=> o_adj_class == SEG_OVERDRIVE && o_adj_dur == $past(i_seg_dur))
		else $error("maximum level not kept as overdrive");

	a_clamp_zero: assert property (
		seg_fire && seg_cls == SEG_SUS_POS && r.sustain_pos_offset == 8'h80
		&& i_playback_step_time == 4'hF && i_seg_dur < DUR_W'(16'h0780)
		|=> o_adj_dur == '0)
		else $error("shortened segment did not clamp at zero");

	c_brake_seen:  cover property (o_adj_valid && o_adj_class == SEG_BRAKE);
	c_overdrive:   cover property (o_adj_valid && o_adj_class == SEG_OVERDRIVE);
	c_clamped:     cover property (o_adj_valid && o_adj_dur == '0);
	c_audio_write: cover property (i_reg_wr && i_reg_addr == ADDR_AUDIO);
	c_scan_done:   cover property (r.st == ST_SCAN && i_scan_done && !i_wave_start);

endmodule : waveform_offset_audio_ctrl_regs
`default_nettype wire

// ==== hw/wave_adj_pkg.sv ====
// How it works
// - positive sustain length plus offset times step
// - positive sustain offset is signed eight bit
// - positive non-overdrive levels are positive sustain
// - negative sustain length plus offset times step
// - negative sustain offset is signed eight bit
// - negative non-brake levels are negative sustain
// - brake length plus signed offset times step
// - most negative level marks the brake segment
// - brake offset ignored in closed loop
// - peak window codes give 10 to 40 ms
// - lowpass codes give 100 to 200 Hz
// - maximum level marks overdrive, not sustain
package wave_adj_pkg;

	// register offsets
	localparam logic [7:0] ADDR_SUS_POS  = 8'h0E;
	localparam logic [7:0] ADDR_SUS_NEG  = 8'h0F;
	localparam logic [7:0] ADDR_BRAKE    = 8'h10;
	localparam logic [7:0] ADDR_AUDIO    = 8'h11;

	// values after reset
	localparam logic [7:0] RST_OFFSET    = 8'h00;
	localparam logic [1:0] RST_PEAK_CODE = 2'h1;
	localparam logic [1:0] RST_LPF_CODE  = 2'h1;

	// audio control field positions
	localparam int         PEAK_LSB      = 2;
	localparam int         LPF_LSB       = 0;

	// extrema seeds for the level scan
	localparam logic [7:0] SCAN_MAX_SEED = 8'h80;
	localparam logic [7:0] SCAN_MIN_SEED = 8'h7F;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SCAN = 2'b01,
		ST_PLAY = 2'b10
	} fsm_type;

	typedef enum logic [2:0] {
		SEG_ZERO      = 3'b000,
		SEG_OVERDRIVE = 3'b001,
		SEG_SUS_POS   = 3'b010,
		SEG_SUS_NEG   = 3'b011,
		SEG_BRAKE     = 3'b100
	} seg_class_type;

	// segment kind from its level and the waveform extrema
	function automatic seg_class_type classify(input logic [7:0] level,
		input logic [7:0] max_lvl, input logic [7:0] min_lvl);
		if ($signed(level) < 0 && level == min_lvl)
			return SEG_BRAKE;
		else if ($signed(level) > 0 && level == max_lvl)
			return SEG_OVERDRIVE;
		else if ($signed(level) > 0)
			return SEG_SUS_POS;
		else if ($signed(level) < 0)
			return SEG_SUS_NEG;
		else
			return SEG_ZERO;
	endfunction : classify

	// peak detection window in ms
	function automatic logic [5:0] peak_window_ms(input logic [1:0] code);
		unique case (code)
			2'h0: return 6'h0A;
			2'h1: return 6'h14;
			2'h2: return 6'h1E;
			2'h3: return 6'h28;
		endcase
	endfunction : peak_window_ms

	// lowpass corner in Hz
	function automatic logic [7:0] lowpass_hz(input logic [1:0] code);
		unique case (code)
			2'h0: return 8'h64;
			2'h1: return 8'h7D;
			2'h2: return 8'h96;
			2'h3: return 8'hC8;
		endcase
	endfunction : lowpass_hz

endpackage : wave_adj_pkg

// ==== hw/wave_adj_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// one segment duration and the offset that applies to it
interface wave_adj_if #(parameter int DUR_W = 16);
	logic [DUR_W-1:0] dur;
	logic [7:0]       offset;
	logic [3:0]       step;
	logic [DUR_W-1:0] result;

	modport ctrl (output dur, output offset, output step, input result);
	modport calc (input dur, input offset, input step, output result);
endinterface : wave_adj_if
`default_nettype wire

// ==== hw/wave_segment_adjust.sv ====
`timescale 1ns/100ps
`default_nettype none
module wave_segment_adjust
	import wave_adj_pkg::*;
(
	wave_adj_if.calc adj
);
	localparam int W = $bits(adj.dur);

	logic signed [12:0]  delta;
	logic signed [W+1:0] sum;

	// signed offset times step, added to duration with two guard bits
	always_comb
	begin
		delta = $signed(adj.offset) * $signed({1'b0, adj.step});
		sum   = $signed({2'b00, adj.dur}) + (W+2)'(delta);
		if (sum < 0)
			adj.result = '0;
		else if (sum[W])
			adj.result = '1; // saturate rather than wrap on long segments
		else
			adj.result = sum[W-1:0];
	end
endmodule : wave_segment_adjust
`default_nettype wire

// ==== tb/wave_stream_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// far side stream: restart, scan each level, close the scan
module wave_stream_model
(
	input  wire logic        i_clk,
	input  wire logic        i_go,
	input  wire logic [31:0] i_levels,
	output var  logic        o_wave_start,
	output var  logic        o_scan_valid,
	output var  logic [7:0]  o_scan_level,
	output var  logic        o_scan_done
);
	initial
	begin
		o_wave_start = 1'b0;
		o_scan_valid = 1'b0;
		o_scan_level = 8'h00;
		o_scan_done = 1'b0;
		forever
		begin
			@(posedge i_clk iff i_go);
			#1;
			o_wave_start = 1'b1;
			@(posedge i_clk);
			#1;
			o_wave_start = 1'b0;
			// top byte first, the last level also closes the scan
			for (int k = 3; k >= 0; k--)
			begin
				o_scan_valid = 1'b1;
				o_scan_level = i_levels[k*8 +: 8];
				o_scan_done = (k == 0);
				@(posedge i_clk);
				#1;
			end
			// released level must not look valid, so invert it
			o_scan_valid = 1'b0;
			o_scan_done = 1'b0;
			o_scan_level = ~o_scan_level;
		end
	end
endmodule : wave_stream_model
`default_nettype wire

// ==== tb/test_waveform_offset_audio_ctrl_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_waveform_offset_audio_ctrl_regs;
	import wave_adj_pkg::*;
	logic          i_clk = 1'b0;
	logic          i_srst = 1'b1;
	logic [7:0]    addr = 8'h00;
	logic          wr = 1'b0;
	logic          rd = 1'b0;
	logic [7:0]    wdata = 8'h00;
	logic          closed_loop = 1'b0;
	logic [3:0]    step = 4'h0;
	logic          go = 1'b0;
	logic          seg_valid = 1'b0;
	logic [7:0]    seg_level = 8'h00;
	logic [15:0]   seg_dur = 16'h0000;
	logic          wave_start, scan_valid, scan_done, seg_ready, adj_valid;
	logic [7:0]    scan_level, rdata, lpf_hz;
	logic [15:0]   adj_dur;
	logic [5:0]    peak_ms;
	seg_class_type adj_class;
	logic [7:0]    offs [3];
	logic [7:0]    lpf_tab [4] = '{8'h64, 8'h7D, 8'h96, 8'hC8};
	int            bad_count = 0;
	int            checked = 0;

	always #5 i_clk = ~i_clk;

	waveform_offset_audio_ctrl_regs dut (.i_clk(i_clk), .i_srst(i_srst),
		.i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .i_closed_loop(closed_loop), .i_playback_step_time(step),
		.i_wave_start(wave_start), .i_scan_valid(scan_valid), .i_scan_level(scan_level),
		.i_scan_done(scan_done), .i_seg_valid(seg_valid), .i_seg_level(seg_level),
		.i_seg_dur(seg_dur), .o_seg_ready(seg_ready), .o_adj_valid(adj_valid),
		.o_adj_class(adj_class), .o_adj_dur(adj_dur),
		.o_audio_peak_window_ms(peak_ms), .o_audio_lowpass_hz(lpf_hz));

	// scan order 7F, 90, 20, A0: max 7F, min 90
	wave_stream_model partner (.i_clk(i_clk), .i_go(go), .i_levels(32'h7F9020A0),
		.o_wave_start(wave_start), .o_scan_valid(scan_valid),
		.o_scan_level(scan_level), .o_scan_done(scan_done));

	task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : cmp_val

	task automatic cmp_class(input logic [2:0] got, input logic [2:0] exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: class %0h expected %0h", $time, got, exp);
		end
	endtask : cmp_class

	// strobes rise one edge after the last fall, never twice in one step
	task automatic reg_access(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge i_clk);
		#1;
		addr = a;
		wdata = d;
		wr = w;
		rd = !w;
		@(posedge i_clk);
		#1;
		wr = 1'b0;
		rd = 1'b0;
	endtask : reg_access

	function automatic logic [15:0] exp_dur(input logic [15:0] d, input logic [7:0] off);
		int v;
		v = int'(d) + int'($signed(off)) * int'(step);
		if (v < 0)
			v = 0;
		if (v > 65535)
			v = 65535;
		return v[15:0];
	endfunction : exp_dur

	// ev: whether the segment is taken at all (refused outside play)
	task automatic seg_check(input logic [7:0] lvl, input logic [15:0] d,
		input logic ev, input logic [2:0] ec, input logic [15:0] ed);
		@(posedge i_clk);
		#1;
		seg_level = lvl;
		seg_dur = d;
		seg_valid = 1'b1;
		@(posedge i_clk);
		#1;
		seg_valid = 1'b0;
		cmp_val({15'h0000, adj_valid}, {15'h0000, ev});
		cmp_class(adj_class, ec);
		cmp_val(adj_dur, ed);
	endtask : seg_check

	// writes the three offsets, reads each back, plays every segment kind
	task automatic play_all(input logic [15:0] d);
		for (int i = 0; i < 3; i++)
		begin
			reg_access(8'h0E + 8'(i), offs[i], 1'b1);
			reg_access(8'h0E + 8'(i), 8'h00, 1'b0);
			cmp_val({8'h00, rdata}, {8'h00, offs[i]});
		end
		seg_check(8'h20, d, 1'b1, 3'h2, exp_dur(d, offs[0]));
		seg_check(8'hA0, d, 1'b1, 3'h3, exp_dur(d, offs[1]));
		seg_check(8'h90, d, 1'b1, 3'h4, closed_loop ? d : exp_dur(d, offs[2]));
		seg_check(8'h7F, d, 1'b1, 3'h1, d);
		seg_check(8'h00, d, 1'b1, 3'h0, d);
	endtask : play_all

	task automatic print_verdict;
		$display("compares %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	// run needs under 3000 cycles
	initial
	begin
		repeat (8000) @(posedge i_clk);
		bad_count++;
		print_verdict();
	end

	initial
	begin
		void'($urandom(32'hF323));
		repeat (16) @(posedge i_clk);
		#1;
		i_srst = 1'b0;
		cmp_val({10'h000, peak_ms}, 16'h0014);
		cmp_val({8'h00, lpf_hz}, 16'h007D);
		for (int i = 0; i < 4; i++)
		begin
			reg_access(8'h0E + 8'(i), 8'h00, 1'b0);
			cmp_val({8'h00, rdata}, (i == 3) ? 16'h0005 : 16'h0000);
		end
		seg_check(8'h20, 16'h0010, 1'b0, 3'h0, 16'h0000);
		$display("reset and idle test done");
		// every code of both fields, junk in the reserved nibble
		for (int c = 0; c < 16; c++)
		begin
			reg_access(8'h11, {4'($urandom()), 4'(c)}, 1'b1);
			cmp_val({10'h000, peak_ms}, 16'(10 * (c / 4 + 1)));
			cmp_val({8'h00, lpf_hz}, {8'h00, lpf_tab[c % 4]});
			reg_access(8'h11, 8'h00, 1'b0);
			cmp_val({8'h00, rdata}, 16'(c));
		end
		reg_access(8'h12, 8'hFF, 1'b1);
		reg_access(8'h12, 8'h00, 1'b0);
		cmp_val({8'h00, rdata}, 16'h0000);
		$display("audio control test done");
		@(posedge i_clk);
		#1;
		go = 1'b1;
		@(posedge i_clk);
		#1;
		go = 1'b0;
		for (int i = 0; i < 20 && seg_ready !== 1'b1; i++)
			@(posedge i_clk);
		cmp_val({15'h0000, seg_ready}, 16'h0001);
		offs = '{8'h01, 8'hFF, 8'h80};
		step = 4'h5;
		play_all(16'h0064);
		offs = '{8'h7F, 8'h81, 8'h7F};
		step = 4'hF;
		play_all(16'hFFF0);
		// full negative clamp, two-step stretch, open loop brake stretch
		offs = '{8'h80, 8'h02, 8'h01};
		closed_loop = 1'b0;
		play_all(16'h0064);
		$display("corner segment test done");
		for (int n = 0; n < 30; n++)
		begin
			offs = '{8'($urandom()), 8'($urandom()), 8'($urandom())};
			step = 4'($urandom());
			closed_loop = 1'($urandom());
			play_all(16'($urandom()));
		end
		$display("random segment test done");
		print_verdict();
	end
endmodule : test_waveform_offset_audio_ctrl_regs
`default_nettype wire
